/* src/sdl_core.sv */
// file: serial dac load interface, device side digital logic
//
// Operation
// - load strobe low copies input shift register into dac register outside frames, with readback not armed
// - load strobe held low: dac register updates at frame select rising edge
// - sixteen-bit words, input bit sampled on each shift clock falling edge
// - readback enabled: dac register shifted out, one bit per rising edge
// - without readback, serial out gives earlier shifted-in bits for daisy chain
// - serial out only pulls low or releases, open drain
// - clear low forces output to output ground reference level
// - clear leaves shift register and dac register untouched
// - clear released: output follows dac register data again
// - power-down asserted puts converter in low-power state
// - load strobe sampled at frame start picks frame-end or later update
// - only 12 or 14 data bits used, straight binary, rest ignored
// - readback word has its two top bits zero
// - power-down never alters dac register contents
`timescale 1ns/100ps
module sdl_core
    import sdl_pkg::*;
#(
    parameter int RESOLUTION = SDL_RES_14
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic frame_n_i,
    input wire logic sclk_i,
    input wire logic serial_in_i,
    input wire logic load_strobe_n_i,
    input wire logic readback_enable_n_i,
    input wire logic clear_n_i,
    input wire logic power_down_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    output logic [15:0] dac_code_o,
    output logic output_at_ground_ref_o,
    output logic low_power_o
);
    sdl_pins_t pins;
    sdl_pins_t pins_raw;

    typedef struct packed {
        sdl_pins_t prev;
        logic [15:0] shift;
        logic [15:0] dac;
        logic [4:0] count;
        logic sync_update;
        logic pending;
        logic readback_armed;
        logic sout;
        logic gnd_ref;
        logic low_power;
    } sdl_state_t;

    sdl_state_t state;
    sdl_state_t next_state;

    // data bits kept for this resolution, others ignored
    localparam logic [15:0] DATA_MASK = 16'(((32'h1 << RESOLUTION) - 1) << (SDL_WORD_BITS - SDL_RB_ZERO_BITS - RESOLUTION));
    localparam logic [15:0] RB_MASK = 16'hFFFF >> SDL_RB_ZERO_BITS;

    assign pins_raw = '{frame_n: frame_n_i, sclk: sclk_i, serial_in: serial_in_i,
                        load_strobe_n: load_strobe_n_i, readback_enable_n: readback_enable_n_i,
                        clear_n: clear_n_i, power_down_n: power_down_n_i};

    sdl_pin_sync #(
        .WIDTH($bits(sdl_pins_t)),
        .RESET_VAL({$bits(sdl_pins_t){1'b1}})
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    logic sclk_fall;
    logic sclk_rise;
    logic frame_fall;
    logic frame_rise;

    always_comb begin
        sclk_fall = state.prev.sclk && !pins.sclk;
        sclk_rise = !state.prev.sclk && pins.sclk;
        frame_fall = state.prev.frame_n && !pins.frame_n;
        frame_rise = !state.prev.frame_n && pins.frame_n;
    end

    always_comb begin
        next_state = state;
        next_state.prev = pins;

        // frame start: catch load strobe to pick update style
        if (frame_fall) begin
            next_state.sync_update = !pins.load_strobe_n;
            next_state.count = SDL_CNT_RESET;
        end

        // shifting is gated by frame select held low by host
        if (sclk_fall && !pins.frame_n) begin
            next_state.shift = {state.shift[14:0], pins.serial_in};
            if (state.count != SDL_CNT_FULL) begin
                next_state.count = state.count + 5'h01;
            end
        end

        // readback: first falling edge with enable low loads dac word into shifter
        if (sclk_fall && !pins.readback_enable_n && !state.readback_armed) begin
            next_state.shift = state.dac & RB_MASK;
            next_state.readback_armed = 1'b1;
        end
        if (pins.readback_enable_n) begin
            next_state.readback_armed = 1'b0;
        end

        // serial out: msb of shifter; rising edge in readback, falling edge otherwise
        if (state.readback_armed && sclk_rise) begin
            next_state.sout = state.shift[15];
        end else if (!state.readback_armed && sclk_fall) begin
            next_state.sout = state.shift[15];
        end

        // word complete at frame end: auto update if strobe was low at start
        if (frame_rise && state.count == SDL_CNT_FULL) begin
            if (state.sync_update) begin
                next_state.dac = state.shift & DATA_MASK;
            end else begin
                next_state.pending = 1'b1;
            end
        end

        // level load: strobe low copies shifter whenever no frame is active and readback is not armed
        // limitation: a strobe pulse that starts and ends inside a frame is lost
        if (!pins.load_strobe_n && pins.frame_n && !state.readback_armed) begin
            next_state.dac = state.shift & DATA_MASK;
            next_state.pending = 1'b0;
        end

        // clear only touches the analog path, never the registers
        next_state.gnd_ref = !pins.clear_n;
        // power-down flag only; dac word untouched
        next_state.low_power = !pins.power_down_n;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state.prev <= '1;
            state.shift <= SDL_WORD_RESET;
            state.dac <= SDL_WORD_RESET;
            state.count <= SDL_CNT_RESET;
            state.sync_update <= 1'b0;
            state.pending <= 1'b0;
            state.readback_armed <= 1'b0;
            state.sout <= 1'b1;
            state.gnd_ref <= 1'b0;
            state.low_power <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // open drain: pull low or release, enable low while driving
    assign serial_out_o = 1'b0;
    assign serial_out_oe_n_o = state.sout;
    assign dac_code_o = state.dac;
    assign output_at_ground_ref_o = state.gnd_ref;
    assign low_power_o = state.low_power;
endmodule

/* src/sdl_pin_sync.sv */
// file: two-flop synchroniser for the external pins
`timescale 1ns/100ps
module sdl_pin_sync
    import sdl_pkg::*;
#(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sdl_sync_state_t;

    sdl_sync_state_t state;
    sdl_sync_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.meta = async_i;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= {RESET_VAL, RESET_VAL};
        end else begin
            state <= next_state;
        end
    end

    assign sync_o = state.stable;
endmodule

/* src/sdl_pkg.sv */
// package: constants and carrier types for the serial dac load interface
package sdl_pkg;
    localparam int SDL_WORD_BITS = 16;
    localparam int SDL_RES_14 = 14;
    localparam int SDL_RES_12 = 12;
    localparam int SDL_RB_ZERO_BITS = 2;
    localparam int SDL_SYNC_STAGES = 2;
    localparam logic [15:0] SDL_WORD_RESET = 16'h0000;
    localparam logic [4:0] SDL_CNT_RESET = 5'h00;
    localparam logic [4:0] SDL_CNT_FULL = 5'h10;

    // host side pins after synchronisation
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic serial_in;
        logic load_strobe_n;
        logic readback_enable_n;
        logic clear_n;
        logic power_down_n;
    } sdl_pins_t;

    // converter-facing state
    typedef struct packed {
        logic [15:0] dac_word;
        logic output_at_ground_ref;
        logic low_power;
    } sdl_conv_t;
endpackage

/* verif/sdl_core_sva.sv */
// checker: port assertions for the serial dac load core
`timescale 1ns/100ps
module sdl_core_sva
    import sdl_pkg::*;
#(
    parameter int RESOLUTION = SDL_RES_14
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic frame_n_i,
    input wire logic load_strobe_n_i,
    input wire logic clear_n_i,
    input wire logic power_down_n_i,
    input wire logic serial_out_o,
    input wire logic [15:0] dac_code_o,
    input wire logic output_at_ground_ref_o,
    input wire logic low_power_o
);
    logic [2:0] idle;
    // counts cycles with neither a frame nor a load strobe pending
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            idle <= 3'h0;
        else if (!(load_strobe_n_i && frame_n_i))
            idle <= 3'h0;
        else if (idle != 3'h7)
            idle <= idle + 3'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    drain_only_a: assert property (serial_out_o == 1'b0) else $error("serial out driven high");
    gnd_enter_a: assert property ($fell(clear_n_i) |-> ##[2:4] output_at_ground_ref_o) else $error("no clear");
    gnd_leave_a: assert property ($rose(clear_n_i) |-> ##[2:4] !output_at_ground_ref_o) else $error("stuck clear");
    pd_enter_a: assert property ($fell(power_down_n_i) |-> ##[2:4] low_power_o) else $error("no power down");
    pd_leave_a: assert property ($rose(power_down_n_i) |-> ##[2:4] !low_power_o) else $error("stuck low power");
    clr_keep_a: assert property ($fell(clear_n_i) && load_strobe_n_i |=> $stable(dac_code_o) [*4]) else $error("clr");
    pd_keep_a: assert property ($fell(power_down_n_i) && load_strobe_n_i |=> $stable(dac_code_o) [*4]) else $error("pd");
    idle_hold_a: assert property (idle >= 3'h5 |-> $stable(dac_code_o)) else $error("load without strobe");
    code_bits_a: assert property (dac_code_o[15:14] == 2'h0 && (RESOLUTION != 12 || dac_code_o[1:0] == 2'h0))
        else $error("unused code bits set");
endmodule
bind sdl_core sdl_core_sva #(.RESOLUTION(RESOLUTION)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .frame_n_i(frame_n_i),
    .load_strobe_n_i(load_strobe_n_i), .clear_n_i(clear_n_i), .power_down_n_i(power_down_n_i),
    .serial_out_o(serial_out_o), .dac_code_o(dac_code_o), .output_at_ground_ref_o(output_at_ground_ref_o),
    .low_power_o(low_power_o));

/* verif/sdl_host.sv */
// partner: host that frames, clocks and collects serial words
`timescale 1ns/100ps
module sdl_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic frame_n_o,
    output logic sclk_o,
    output logic serial_in_o,
    output logic [15:0] rx_o
);
    initial begin
        frame_n_o = 1'b1;
        sclk_o = 1'b1;
        serial_in_o = 1'b0;
        rx_o = 16'h0000;
    end
    // sclk idles high; data moves at the rise, device takes it at the fall
    // serial out is taken at each fall, a full period after a daisy (fall) launch
    // and half a period after a readback (rise) launch, which suits both edges
    task automatic send(input logic [15:0] w);
        frame_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in_o <= w[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            rx_o <= {rx_o[14:0], sdo_i};
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
        rx_o <= {rx_o[14:0], sdo_i};
        frame_n_o <= 1'b1;
        serial_in_o <= ~serial_in_o;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

/* verif/tb_top.sv */
// testbench: words, load strobe, chain, clear and power-down
`timescale 1ns/100ps
module tb_top;
    import sdl_pkg::*;
    logic clk_i, rst_n_i, load_n, rb_n, clr_n, pd_n, frame_n, sclk, sdi, serial_out, sdo_d, oe_n, gnd, lp;
    logic [15:0] rx, dac, w, prev, cur;
    int seed, miscompares, tests_run;
    sdl_host host (.clk_i(clk_i), .sdo_i(serial_out), .frame_n_o(frame_n), .sclk_o(sclk), .serial_in_o(sdi), .rx_o(rx));
    sdl_core #(.RESOLUTION(SDL_RES_14)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .frame_n_i(frame_n), .sclk_i(sclk),
        .serial_in_i(sdi), .load_strobe_n_i(load_n), .readback_enable_n_i(rb_n), .clear_n_i(clr_n),
        .power_down_n_i(pd_n), .serial_out_o(sdo_d), .serial_out_oe_n_o(oe_n), .dac_code_o(dac),
        .output_at_ground_ref_o(gnd), .low_power_o(lp));
    assign serial_out = oe_n ? 1'b1 : sdo_d;
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    function automatic logic [15:0] data_of(input logic [15:0] v);
        return v & 16'h3FFF;
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    initial begin
        #1000000;
        miscompares++;
        print_verdict;
    end
    initial begin
        {seed, miscompares, tests_run} = {32'd57, 32'd0, 32'd0};
        {rst_n_i, load_n, rb_n, clr_n, pd_n, prev, cur} = {5'b01111, 32'h0};
        tick(2);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            w = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
            load_n <= k[0];
            tick(4);
            host.send(w);
            tick(6);
            if (!k[0])
                cur = data_of(w);
            check("dac", cur, dac);
            check("chain", prev, rx);
            if (k[0]) begin
                load_n <= 1'b0;
                tick(2);
                load_n <= 1'b1;
                tick(6);
                cur = data_of(w);
                check("dac", cur, dac);
            end
            prev = w;
        end
        // readback: dac word comes back msb first with top bits zero
        rb_n <= 1'b0;
        tick(4);
        w = 16'($random(seed));
        host.send(w);
        tick(6);
        check("readback", cur, rx);
        check("dac", cur, dac);
        rb_n <= 1'b1;
        tick(4);
        clr_n <= 1'b0;
        tick(6);
        check("gnd", 16'h0001, {15'h0000, gnd});
        check("dac", cur, dac);
        clr_n <= 1'b1;
        pd_n <= 1'b0;
        tick(6);
        check("gnd", 16'h0000, {15'h0000, gnd});
        check("pwr", 16'h0001, {15'h0000, lp});
        pd_n <= 1'b1;
        tick(6);
        check("pwr", 16'h0000, {15'h0000, lp});
        check("dac", cur, dac);
        print_verdict;
    end
endmodule
